// ### inc/bsr_defines.vh
`ifndef BSR_DEFINES_VH
`define BSR_DEFINES_VH

// Register word addresses on the plain register port.
`define BSR_ADDR_W            3
`define BSR_OFS_SLEEP_CTRL    3'h0
`define BSR_OFS_WAKE_SOURCE   3'h1
`define BSR_OFS_RESET_STATUS  3'h2
`define BSR_OFS_SEM_A         3'h3
`define BSR_OFS_SEM_B         3'h4
`define BSR_OFS_RET_CTRL      3'h5

// Deep-sleep control fields.
`define BSR_CTL_REQUEST_BIT   15
`define BSR_CTL_BROWNOUT_BIT  1
`define BSR_CTL_HOLD_BIT      0

// Wake-source fields.
`define BSR_WK_EXT_INT_BIT    8
`define BSR_WK_FAULT_BIT      7
`define BSR_WK_WDT_BIT        4
`define BSR_WK_ALARM_BIT      3
`define BSR_WK_MASTER_RESET_PIN_BIT       2
`define BSR_WK_MASK           16'h019c

// Reset and supply status fields.
`define BSR_ST_MAIN_BOR_BIT   3
`define BSR_ST_MAIN_POR_BIT   2
`define BSR_ST_BACKUP_RST_BIT 1
`define BSR_ST_BACKUP_EXIT_BIT 0
`define BSR_ST_RESET_VAL      4'he

// Retention control fields.
`define BSR_RC_CAL_EN_BIT     0
`define BSR_RC_CAL_SRC_BIT    1

// Reset values.
`define BSR_CTL_RESET_VAL     16'h0000
`define BSR_WAKE_RESET_VAL    16'h0000
`define BSR_SEM_RESET_VAL     16'h0000

// Timing.
`define BSR_CLK_MHZ           40
`define BSR_POR_HOLD_NS       1000
`define BSR_POR_HOLD_CYC      ((`BSR_POR_HOLD_NS * `BSR_CLK_MHZ + 999) / 1000)

`endif

// ### logic/bsr_sync.v
`timescale 1ns/1ps
`default_nettype none

module bsr_sync #(
  parameter WIDTH = 11,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_i,
  input  wire             resetn_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      stage1 <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule // bsr_sync

`default_nettype wire

// ### logic/bsr_top.v
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bsr_defines.vh"

// Contract
// - Main supply loss enters backup mode automatically.
// - Backup keeps only calendar and semaphores.
// - Calendar keeps its pre-switch clock source.
// - Config bit zero stops calendar in backup.
// - Supply return wakes via power-on reset.
// - Calendar not run in backup stays off.
// - Backup exit sets flag; software clears.
// - Reset without backup source sets backup-reset flag.
// - Backup below retention level sets backup-reset flag.
// - First power-up sets backup-reset flag.
// - Backup makes pins inputs, oscillator pins excepted.
// - Deep-sleep request clears all wake flags.
// - Control bits reset only outside deep sleep.
// - Sleep brown-out flag set on detected event.
// - Sleep brown-out does not wake; re-arms reset.
// - Pin hold set by hardware, software clears.
// - Wake flags set by their wake events.
// - Fault flag set on sleep fault.
// - Main brown-out and power-on flags clear-only.
// - Unimplemented bits read zero.
// - Control write needs two consecutive writes.
module bsr_top #(
  parameter [15:0] POR_HOLD = `BSR_POR_HOLD_CYC
) (
  input  wire                   clk_i,
  input  wire                   resetn_i,
  input  wire [`BSR_ADDR_W-1:0] addr_i,
  input  wire [15:0]            wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [15:0]            rdata_o,
  input  wire                   power_save_instruction_i,
  input  wire                   main_supply_ok_i,
  input  wire                   backup_supply_ok_i,
  input  wire                   main_brownout_i,
  input  wire                   ext_interrupt_i,
  input  wire                   sleep_watchdog_timeout_i,
  input  wire                   calendar_alarm_i,
  input  wire                   master_reset_pin_n_i,
  input  wire                   sleep_fault_i,
  input  wire                   sleep_brownout_i,
  input  wire                   sleep_brownout_enable_i,
  input  wire                   calendar_in_backup_cfg_i,
  output reg                    backup_switch_o,
  output reg                    main_domain_power_o,
  output reg                    calendar_run_o,
  output reg                    calendar_src_o,
  output reg                    core_reset_n_o,
  output reg                    reset_vector_fetch_o,
  output reg                    deep_sleep_o,
  output reg                    por_rearm_o,
  output reg                    pin_hold_o,
  output reg                    pin_force_input_o,
  output reg                    sec_osc_pins_keep_o
);

  localparam ST_RUN    = 4'b0001;
  localparam ST_SLEEP  = 4'b0010;
  localparam ST_BACKUP = 4'b0100;
  localparam ST_WAKE   = 4'b1000;

  // Supplies read as good and the master reset pin as released until the synchronisers fill.
  localparam [10:0] SYNC_RESET = 11'h043;

  wire [10:0] pins_sync;
  wire        s_main_ok    = pins_sync[0];
  wire        s_backup_ok  = pins_sync[1];
  wire        s_main_bor   = pins_sync[2];
  wire        s_ext_int    = pins_sync[3];
  wire        s_wdt        = pins_sync[4];
  wire        s_alarm      = pins_sync[5];
  wire        s_master_reset_pin_n     = pins_sync[6];
  wire        s_fault      = pins_sync[7];
  wire        s_sleep_bor  = pins_sync[8];
  wire        s_sleep_bor_en = pins_sync[9];
  wire        s_cal_cfg    = pins_sync[10];

  reg  [3:0]  state;
  reg  [15:0] hold_cnt;
  reg         deep_sleep_request;
  reg         sleep_brownout_event;
  reg         pin_hold;
  reg  [15:0] wake_source;
  reg  [3:0]  reset_status;
  reg  [15:0] semaphore_store_a;
  reg  [15:0] semaphore_store_b;
  reg         cal_en;
  reg         cal_src;
  reg         cal_src_frozen;
  reg         backup_lost;
  reg         ext_int_prev;
  reg         ctl_unlocked;

  wire        bus_live  = state[0];
  wire        wr_ctl    = wr_i & bus_live & (addr_i == `BSR_OFS_SLEEP_CTRL);
  wire        wr_wake   = wr_i & bus_live & (addr_i == `BSR_OFS_WAKE_SOURCE);
  wire        wr_status = wr_i & bus_live & (addr_i == `BSR_OFS_RESET_STATUS);
  wire        wr_sem_a  = wr_i & bus_live & (addr_i == `BSR_OFS_SEM_A);
  wire        wr_sem_b  = wr_i & bus_live & (addr_i == `BSR_OFS_SEM_B);
  wire        wr_ret    = wr_i & bus_live & (addr_i == `BSR_OFS_RET_CTRL);

  // Only the second of two back-to-back control writes takes effect.
  wire        ctl_commit = wr_ctl & ctl_unlocked;
  wire        request_rise = ctl_commit & wdata_i[`BSR_CTL_REQUEST_BIT] & ~deep_sleep_request;

  wire        ext_int_edge = s_ext_int & ~ext_int_prev;
  wire        in_capture   = deep_sleep_request | pin_hold;

  wire [15:0] wake_hits = {7'h00, ext_int_edge, s_fault, 2'b00, s_wdt, s_alarm, ~s_master_reset_pin_n, 2'b00};
  wire        wake_event = ext_int_edge | s_wdt | s_alarm | ~s_master_reset_pin_n;

  function [15:0] bsr_ctl_word;
    input req;
    input bor;
    input hold;
    begin
      bsr_ctl_word = 16'h0000;
      bsr_ctl_word[`BSR_CTL_REQUEST_BIT]  = req;
      bsr_ctl_word[`BSR_CTL_BROWNOUT_BIT] = bor;
      bsr_ctl_word[`BSR_CTL_HOLD_BIT]     = hold;
    end
  endfunction

  bsr_sync #(
    .WIDTH     (11),
    .RESET_VAL (SYNC_RESET)
  ) u_pin_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({calendar_in_backup_cfg_i, sleep_brownout_enable_i, sleep_brownout_i, sleep_fault_i,
                master_reset_pin_n_i, calendar_alarm_i, sleep_watchdog_timeout_i, ext_interrupt_i,
                main_brownout_i, backup_supply_ok_i, main_supply_ok_i}),
    .sync_o   (pins_sync)
  );

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ext_int_prev <= 1'b0;
    end else begin
      ext_int_prev <= s_ext_int;
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ctl_unlocked <= 1'b0;
    end else if (wr_i) begin
      ctl_unlocked <= wr_ctl & ~ctl_unlocked;
    end
  end

  // Power-mode sequencer.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state                <= ST_RUN;
      hold_cnt             <= 16'h0000;
      backup_lost          <= 1'b0;
      cal_src_frozen       <= 1'b0;
      reset_vector_fetch_o <= 1'b0;
      por_rearm_o          <= 1'b0;
    end else begin
      reset_vector_fetch_o <= 1'b0;
      por_rearm_o          <= 1'b0;
      case (state)
        ST_RUN: begin
          if (!s_main_ok) begin
            state          <= ST_BACKUP;
            backup_lost    <= ~s_backup_ok;
            cal_src_frozen <= cal_src;
          end else if (deep_sleep_request && power_save_instruction_i) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!s_main_ok) begin
            state          <= ST_BACKUP;
            backup_lost    <= ~s_backup_ok;
            cal_src_frozen <= cal_src;
          end else if (wake_event) begin
            state    <= ST_WAKE;
            hold_cnt <= POR_HOLD;
          end else if (s_sleep_bor && s_sleep_bor_en) begin
            por_rearm_o <= 1'b1;
          end
        end
        ST_BACKUP: begin
          if (!s_backup_ok) begin
            backup_lost <= 1'b1;
          end
          if (s_main_ok) begin
            state    <= ST_WAKE;
            hold_cnt <= POR_HOLD;
          end
        end
        ST_WAKE: begin
          if (!s_main_ok) begin
            state          <= ST_BACKUP;
            backup_lost    <= ~s_backup_ok;
            cal_src_frozen <= cal_src;
          end else if (hold_cnt <= 16'h0001) begin
            state                <= ST_RUN;
            hold_cnt             <= 16'h0000;
            reset_vector_fetch_o <= 1'b1;
          end else begin
            hold_cnt <= hold_cnt - 16'h0001;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  wire backup_return = state[2] & s_main_ok;
  wire sleep_wake    = state[1] & s_main_ok & wake_event;

  // Deep-sleep control register.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      deep_sleep_request   <= 1'b0;
      sleep_brownout_event <= 1'b0;
      pin_hold             <= 1'b0;
    end else if (backup_return) begin
      // Reset by a power-on reset outside deep sleep.
      deep_sleep_request   <= 1'b0;
      sleep_brownout_event <= 1'b0;
      pin_hold             <= 1'b0;
    end else begin
      if (sleep_wake) begin
        deep_sleep_request <= 1'b0;
      end else if (ctl_commit) begin
        deep_sleep_request <= wdata_i[`BSR_CTL_REQUEST_BIT];
      end
      if (state[1] && s_sleep_bor && s_sleep_bor_en) begin
        sleep_brownout_event <= 1'b1;
      end else if (ctl_commit) begin
        sleep_brownout_event <= wdata_i[`BSR_CTL_BROWNOUT_BIT];
      end
      // Hardware sets hold on entry; software may only clear.
      if (state[0] && deep_sleep_request && power_save_instruction_i && s_main_ok) begin
        pin_hold <= 1'b1;
      end else if (ctl_commit && !wdata_i[`BSR_CTL_HOLD_BIT]) begin
        pin_hold <= 1'b0;
      end
    end
  end

  // Wake-source register; a hardware set wins over a software clear, while reset and backup_return clear it outright.
  always @(posedge clk_i) begin
    if (!resetn_i || backup_return) begin
      wake_source <= `BSR_WAKE_RESET_VAL;
    end else if (request_rise) begin
      wake_source <= in_capture ? (wake_hits & `BSR_WK_MASK) : 16'h0000;
    end else begin
      wake_source <= ((wr_wake ? wdata_i : wake_source) | (in_capture ? wake_hits : 16'h0000))
                     & `BSR_WK_MASK;
    end
  end

  // Reset and supply status, clear-only from software.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      reset_status <= `BSR_ST_RESET_VAL;
    end else begin
      reset_status <= (wr_status ? (reset_status & wdata_i[3:0]) : reset_status);
      if (state[0] && s_main_bor) begin
        reset_status[`BSR_ST_MAIN_BOR_BIT] <= 1'b1;
      end
      if (backup_return) begin
        reset_status[`BSR_ST_MAIN_POR_BIT] <= 1'b1;
        if (!backup_lost && s_backup_ok) begin
          reset_status[`BSR_ST_BACKUP_EXIT_BIT] <= 1'b1;
        end
        if (backup_lost || !s_backup_ok) begin
          reset_status[`BSR_ST_BACKUP_RST_BIT] <= 1'b1;
        end
      end
    end
  end

  // Semaphore stores survive every wake unless the backup source was lost.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      semaphore_store_a <= `BSR_SEM_RESET_VAL;
      semaphore_store_b <= `BSR_SEM_RESET_VAL;
    end else if (state[2] && !s_backup_ok) begin
      // Contents are gone once retention fails.
      semaphore_store_a <= `BSR_SEM_RESET_VAL;
      semaphore_store_b <= `BSR_SEM_RESET_VAL;
    end else begin
      if (wr_sem_a) begin
        semaphore_store_a <= wdata_i;
      end
      if (wr_sem_b) begin
        semaphore_store_b <= wdata_i;
      end
    end
  end

  // Calendar enable and clock source.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cal_en  <= 1'b0;
      cal_src <= 1'b0;
    end else if (backup_return) begin
      // Stays off if it did not run in backup.
      cal_en <= cal_en & s_cal_cfg & ~backup_lost & s_backup_ok;
    end else if (wr_ret) begin
      cal_en  <= wdata_i[`BSR_RC_CAL_EN_BIT];
      cal_src <= wdata_i[`BSR_RC_CAL_SRC_BIT];
    end
  end

  // Registered outputs.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      backup_switch_o     <= 1'b0;
      main_domain_power_o <= 1'b1;
      calendar_run_o      <= 1'b0;
      calendar_src_o      <= 1'b0;
      core_reset_n_o      <= 1'b0;
      deep_sleep_o        <= 1'b0;
      pin_hold_o          <= 1'b0;
      pin_force_input_o   <= 1'b0;
      sec_osc_pins_keep_o <= 1'b0;
    end else begin
      // Retained domain routed to backup, rest unpowered.
      backup_switch_o     <= state[2];
      main_domain_power_o <= ~state[2] & ~state[1];
      // Frozen source; config bit gates the run.
      calendar_run_o      <= state[2] ? (cal_en & s_cal_cfg & ~backup_lost & s_backup_ok) : cal_en;
      calendar_src_o      <= state[2] ? cal_src_frozen : cal_src;
      core_reset_n_o      <= state[0];
      deep_sleep_o        <= state[1];
      pin_hold_o          <= pin_hold & ~state[2];
      // All pins input; oscillator pins kept when they clock the calendar.
      pin_force_input_o   <= state[2];
      sec_osc_pins_keep_o <= state[2] & cal_en & s_cal_cfg & ~cal_src_frozen & ~backup_lost;
    end
  end

  // Register read port, data one cycle after the strobe.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      // Unimplemented and reserved bits read zero.
      case (addr_i)
        `BSR_OFS_SLEEP_CTRL:   rdata_o <= bsr_ctl_word(deep_sleep_request, sleep_brownout_event, pin_hold);
        `BSR_OFS_WAKE_SOURCE:  rdata_o <= wake_source;
        `BSR_OFS_RESET_STATUS: rdata_o <= {12'h000, reset_status};
        `BSR_OFS_SEM_A:        rdata_o <= semaphore_store_a;
        `BSR_OFS_SEM_B:        rdata_o <= semaphore_store_b;
        `BSR_OFS_RET_CTRL:     rdata_o <= {14'h0000, cal_src, cal_en};
        default:               rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // bsr_top

`default_nettype wire

// ### testbench/bsr_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsr_defines.vh"

module bsr_chk #(
  parameter [15:0] POR_HOLD = `BSR_POR_HOLD_CYC
) (
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire logic [`BSR_ADDR_W-1:0] addr_i,
  input wire logic                   rd_i,
  input wire logic [15:0]            rdata_o,
  input wire logic                   calendar_in_backup_cfg_i,
  input wire logic                   backup_switch_o,
  input wire logic                   main_domain_power_o,
  input wire logic                   calendar_run_o,
  input wire logic                   calendar_src_o,
  input wire logic                   core_reset_n_o,
  input wire logic                   reset_vector_fetch_o,
  input wire logic                   deep_sleep_o,
  input wire logic                   por_rearm_o,
  input wire logic                   pin_hold_o,
  input wire logic                   pin_force_input_o
);
  // The window opens after the input synchronisers have passed the supply return, so the margin is slack on top of the power-on hold time.
  localparam int WAKE_MAX = POR_HOLD + 16;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  function automatic logic [15:0] impl_mask(input logic [`BSR_ADDR_W-1:0] a);
    case (a)
      `BSR_OFS_SLEEP_CTRL: impl_mask = 16'h8003;
      `BSR_OFS_WAKE_SOURCE: impl_mask = `BSR_WK_MASK;
      `BSR_OFS_RESET_STATUS: impl_mask = 16'h000f;
      `BSR_OFS_SEM_A, `BSR_OFS_SEM_B, `BSR_OFS_RET_CTRL: impl_mask = 16'hffff;
      default: impl_mask = 16'h0000;
    endcase
  endfunction

  sequence wake_start_s;
    $fell(backup_switch_o);
  endsequence

  sequence wake_end_s;
    ##[1:WAKE_MAX] reset_vector_fetch_o ##1 core_reset_n_o;
  endsequence

  rdata_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside a read answer");
  unimpl_bits_a: assert property ($past(rd_i) |-> (rdata_o & ~impl_mask($past(addr_i))) == 16'h0000)
    else $error("unimplemented bit read as one");
  backup_pins_a: assert property (backup_switch_o |-> pin_force_input_o && !main_domain_power_o && !core_reset_n_o)
    else $error("backup mode without inputs forced or with main domain alive");
  cal_off_a: assert property (backup_switch_o && !calendar_in_backup_cfg_i |-> !calendar_run_o)
    else $error("calendar runs in backup although disabled");
  cal_src_a: assert property (backup_switch_o && $past(backup_switch_o) |-> $stable(calendar_src_o))
    else $error("calendar source changed in backup");
  wake_seq_a: assert property (wake_start_s |-> wake_end_s)
    else $error("supply return did not end in a reset vector fetch");
  fetch_pulse_a: assert property (reset_vector_fetch_o |=> !reset_vector_fetch_o && core_reset_n_o)
    else $error("vector fetch pulse not followed by run");
  rearm_sleep_a: assert property (por_rearm_o |-> deep_sleep_o && !core_reset_n_o)
    else $error("sleep brown-out rearm outside deep sleep");
  hold_rise_a: assert property ($rose(pin_hold_o) |-> deep_sleep_o || $past(deep_sleep_o))
    else $error("pin hold set away from deep sleep");
endmodule // bsr_chk

bind bsr_top bsr_chk #(.POR_HOLD(POR_HOLD)) u_chk (.clk_i, .resetn_i, .addr_i, .rd_i, .rdata_o,
  .calendar_in_backup_cfg_i, .backup_switch_o, .main_domain_power_o, .calendar_run_o, .calendar_src_o,
  .core_reset_n_o, .reset_vector_fetch_o, .deep_sleep_o, .por_rearm_o, .pin_hold_o, .pin_force_input_o);

`default_nettype wire

// ### testbench/bsr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsr_defines.vh"

module bsr_tb_top;
  localparam logic [2:0] CTL = `BSR_OFS_SLEEP_CTRL;
  localparam logic [2:0] WAK = `BSR_OFS_WAKE_SOURCE;
  localparam logic [2:0] STS = `BSR_OFS_RESET_STATUS;
  localparam logic [2:0] SMA = `BSR_OFS_SEM_A;
  localparam logic [2:0] RET = `BSR_OFS_RET_CTRL;
  logic        clk_i = 1'b0;
  logic        resetn_i, wr_i, rd_i, power_save_instruction_i, main_supply_ok_i, backup_supply_ok_i;
  logic        main_brownout_i, ext_interrupt_i, sleep_watchdog_timeout_i, calendar_alarm_i;
  logic        master_reset_pin_n_i, sleep_fault_i, sleep_brownout_i, sleep_brownout_enable_i;
  logic        calendar_in_backup_cfg_i;
  logic [2:0]  addr_i;
  logic [15:0] wdata_i, d;
  wire  [15:0] rdata_o;
  wire         backup_switch_o, main_domain_power_o, calendar_run_o, calendar_src_o, core_reset_n_o;
  wire         reset_vector_fetch_o, deep_sleep_o, por_rearm_o, pin_hold_o, pin_force_input_o;
  wire         sec_osc_pins_keep_o;
  int          err_count = 0;
  int          n_tests = 0;
  int          k;
  logic [15:0] wake_exp [3] = '{16'h0100, 16'h0090, 16'h0004};

  // A short power-on hold keeps every wake-up sequence brief.
  bsr_top #(.POR_HOLD(16'h0002)) u_dut (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .power_save_instruction_i, .main_supply_ok_i, .backup_supply_ok_i, .main_brownout_i, .ext_interrupt_i,
    .sleep_watchdog_timeout_i, .calendar_alarm_i, .master_reset_pin_n_i, .sleep_fault_i, .sleep_brownout_i,
    .sleep_brownout_enable_i, .calendar_in_backup_cfg_i, .backup_switch_o, .main_domain_power_o,
    .calendar_run_o, .calendar_src_o, .core_reset_n_o, .reset_vector_fetch_o, .deep_sleep_o, .por_rearm_o,
    .pin_hold_o, .pin_force_input_o, .sec_osc_pins_keep_o);

  always #12.5 clk_i = ~clk_i;

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holding the strobe for n cycles gives n back-to-back writes.
  task automatic wr(input logic [2:0] a, input logic [15:0] v, input int n);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    repeat (n) @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rc(input logic [2:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    chk(what, d, exp);
  endtask

  function automatic logic obs(input int s);
    case (s)
      0: obs = backup_switch_o;
      1: obs = deep_sleep_o;
      default: obs = core_reset_n_o;
    endcase
  endfunction

  task automatic wt(input int s, input logic v);
    int i;
    for (i = 0; i < 100 && obs(s) !== v; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (obs(s) !== v) begin
      chk("wait", 16'h0000, 16'h0001);
      give_verdict();
    end
    // Return on a rising edge so that the caller drives inputs there.
    @(posedge clk_i);
  endtask

  task automatic sleep_enter();
    @(posedge clk_i);
    power_save_instruction_i <= 1'b1;
    @(posedge clk_i);
    power_save_instruction_i <= 1'b0;
    wt(1, 1'b1);
  endtask

  task automatic supply(input logic ok);
    @(posedge clk_i);
    main_supply_ok_i <= ok;
    wt(ok ? 2 : 0, 1'b1);
  endtask

  initial begin
    {resetn_i, wr_i, rd_i, power_save_instruction_i, main_brownout_i, ext_interrupt_i} = 6'h00;
    {sleep_watchdog_timeout_i, calendar_alarm_i, sleep_fault_i, sleep_brownout_i} = 4'h0;
    {main_supply_ok_i, backup_supply_ok_i, master_reset_pin_n_i, calendar_in_backup_cfg_i} = 4'hf;
    sleep_brownout_enable_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    wt(2, 1'b1);
    rc(STS, 16'h000e, "status at power-up");
    rc(CTL, 16'h0000, "control at power-up");
    rc(3'h7, 16'h0000, "unmapped");
    wr(STS, 16'h0000, 1);
    rc(STS, 16'h0000, "status cleared");
    wr(STS, 16'hffff, 1);
    rc(STS, 16'h0000, "status not settable");
    main_brownout_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    main_brownout_i <= 1'b0;
    rc(STS, 16'h0008, "main brown-out flag");
    wr(CTL, 16'h0002, 1);
    rc(CTL, 16'h0000, "single control write");
    wr(SMA, 16'ha5a5, 1);
    wr(`BSR_OFS_SEM_B, 16'h5a5a, 1);
    wr(RET, 16'h0001, 1);
    wr(CTL, 16'h0002, 2);
    rc(CTL, 16'h0002, "double control write");
    supply(1'b0);
    chk("backup outputs", {12'h0, pin_force_input_o, main_domain_power_o, calendar_run_o, sec_osc_pins_keep_o},
        16'h000b);
    repeat (5) @(posedge clk_i);
    supply(1'b1);
    rc(STS, 16'h000d, "status after backup");
    rc(SMA, 16'ha5a5, "semaphore kept");
    rc(`BSR_OFS_SEM_B, 16'h5a5a, "second semaphore kept");
    rc(CTL, 16'h0000, "control after backup");
    wr(STS, 16'h0000, 1);
    wr(RET, 16'h0001, 1);
    calendar_in_backup_cfg_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    supply(1'b0);
    chk("calendar in backup", {14'h0, calendar_run_o, sec_osc_pins_keep_o}, 16'h0000);
    supply(1'b1);
    repeat (3) @(posedge clk_i);
    chk("calendar after wake", {15'h0, calendar_run_o}, 16'h0000);
    calendar_in_backup_cfg_i <= 1'b1;
    supply(1'b0);
    backup_supply_ok_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    backup_supply_ok_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    supply(1'b1);
    rc(SMA, 16'h0000, "semaphore lost");
    rc(STS, 16'h0007, "status after loss");
    chk("backup reset flag", d & 16'h0002, 16'h0002);
    wr(CTL, 16'h8000, 2);
    sleep_enter();
    sleep_brownout_enable_i <= 1'b1;
    sleep_brownout_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("sleep through brown-out", {12'h0, deep_sleep_o, pin_hold_o, por_rearm_o, main_domain_power_o},
        16'h000e);
    sleep_brownout_i <= 1'b0;
    calendar_alarm_i <= 1'b1;
    wt(2, 1'b1);
    calendar_alarm_i <= 1'b0;
    rc(WAK, 16'h0008, "alarm wake");
    rc(CTL, 16'h0003, "control after sleep");
    for (k = 0; k < 3; k++) begin
      wr(CTL, 16'h8000, 2);
      rc(WAK, 16'h0000, "wake flags cleared");
      sleep_enter();
      @(posedge clk_i);
      case (k)
        0: ext_interrupt_i <= 1'b1;
        1: begin
          sleep_watchdog_timeout_i <= 1'b1;
          sleep_fault_i <= 1'b1;
        end
        default: master_reset_pin_n_i <= 1'b0;
      endcase
      wt(2, 1'b1);
      {ext_interrupt_i, sleep_watchdog_timeout_i, sleep_fault_i, master_reset_pin_n_i} <= 4'h1;
      rc(WAK, wake_exp[k], "wake source");
    end
    wr(CTL, 16'h0000, 2);
    repeat (3) @(posedge clk_i);
    chk("pin hold released", {15'h0, pin_hold_o}, 16'h0000);
    give_verdict();
  end
endmodule // bsr_tb_top

`default_nettype wire
